// ---- core/esc_pkg.sv ----
// Purpose: Shared constants and types for the E1 signaling change status
// Assumes: 32-bit APB, register index times four gives the byte address
// Notes: Channel numbering is zero based inside the logic
package esc_pkg;

	// ------------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------------
	localparam logic [15:0] FRM_CTRL_IDX = 16'h010B;
	localparam logic [15:0] SIGCHG0_IDX = 16'h010D;
	localparam logic [15:0] SIGCHG3_IDX = 16'h0110;
	localparam logic [15:0] STATUS_IDX = 16'h0B04;
	localparam logic [15:0] MASK_IDX = 16'h0B14;
	localparam logic [15:0] CTRL_IDX = 16'h0B15;
	localparam logic [15:0] FRM_CTRL_ADDR = 16'h042C;
	localparam logic [15:0] SIGCHG0_ADDR = 16'h0434;
	localparam logic [15:0] SIGCHG1_ADDR = 16'h0438;
	localparam logic [15:0] SIGCHG2_ADDR = 16'h043C;
	localparam logic [15:0] SIGCHG3_ADDR = 16'h0440;
	localparam logic [15:0] STATUS_ADDR = 16'h2C10;
	localparam logic [15:0] MASK_ADDR = 16'h2C50;
	localparam logic [15:0] CTRL_ADDR = 16'h2C54;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int CAS_FLAG_BIT = 7;
	localparam int NAT_FLAG_BIT = 6;
	localparam int SIG_FLAG_BIT = 5;
	localparam int THR_LSB = 5;
	localparam int THR_MSB = 6;
	localparam int CTRL_CAS_EN_BIT = 0;
	localparam logic [7:0] FRM_CTRL_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] FLAG_MASK = 8'hE0;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int SIG_CHANNELS = 30;
	localparam int CHAN_W = 5;
	localparam int NAT_W = 5;
	localparam int ABCD_W = 4;
	localparam int CNT_W = 3;

	// Register selected by an APB address
	typedef enum {
		ESC_SEL_NONE,
		ESC_SEL_FRM,
		ESC_SEL_SIG0,
		ESC_SEL_SIG1,
		ESC_SEL_SIG2,
		ESC_SEL_SIG3,
		ESC_SEL_STATUS,
		ESC_SEL_MASK,
		ESC_SEL_CTRL
	} esc_sel_type;

	// Reports from the receive framer detectors
	typedef struct packed {
		logic cas_pat_strobe;
		logic cas_pat_err;
		logic nfas_strobe;
		logic [NAT_W-1:0] nat_bits;
		logic sig_strobe;
		logic [CHAN_W-1:0] sig_chan;
		logic [ABCD_W-1:0] sig_abcd;
	} esc_det_type;

endpackage

// ---- core/esc_sig_tracker.sv ----
// Purpose: Remembers the ABCD bits of each signaling channel, flags changes
// Assumes: One channel report per strobe, same clock as the framer
// Notes: The first report of a channel after reset only primes the memory
`timescale 1ns/1ps
`default_nettype none

module esc_sig_tracker #(
	parameter int CHANNELS = esc_pkg::SIG_CHANNELS
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic strobe_i,
	input wire logic [esc_pkg::CHAN_W-1:0] chan_i,
	input wire logic [esc_pkg::ABCD_W-1:0] abcd_i,
	output logic chg_o,
	output logic [CHANNELS-1:0] chg_vec_o
);

	typedef struct packed {
		logic [CHANNELS-1:0][esc_pkg::ABCD_W-1:0] last;
		logic [CHANNELS-1:0] seen;
	} esc_trk_type;

	esc_trk_type st_reg;
	esc_trk_type st_next;
	logic in_range;
	logic hit;

	// Compare the new report with the remembered value of its channel
	assign in_range = chan_i < CHANNELS[esc_pkg::CHAN_W-1:0];
	assign hit = strobe_i && in_range && st_reg.seen[chan_i]
		&& (st_reg.last[chan_i] != abcd_i);
	assign chg_o = hit;

	// One-hot channel of the change
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_vec
			assign chg_vec_o[g] = hit
				&& (chan_i == esc_pkg::CHAN_W'(g));
		end
	endgenerate

	// Store the latest bits of the reported channel
	always_comb begin
		st_next = st_reg;
		if (strobe_i && in_range) begin
			st_next.last[chan_i] = abcd_i;
			st_next.seen[chan_i] = 1'b1;
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule // esc_sig_tracker

`default_nettype wire

// ---- core/esc_status.sv ----
// Purpose: Signaling, national bit and CAS alignment change status for E1
// Assumes: Detector reports arrive on mclk_i; software uses APB
// Notes: Status and channel change registers clear the bits a read returns
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Loss of CAS alignment sets bit 7
// - Regaining CAS alignment also sets bit 7
// - Loss after programmed count of errored patterns
// - CAS and signaling flags only with CAS
// - National bit change sets bit 6
// - ABCD change in any channel sets bit 5
// - Per-channel change registers show the culprit
// - Flags show events since read; read clears
module esc_status #(
	parameter int ADDR_W = 16
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire esc_pkg::esc_det_type det_i,
	output logic cas_loss_o,
	output logic irq_o
);

	// ------------------------------------------------------------------
	// Types and state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] frm_ctrl;
		logic [7:0] ctrl;
		logic [7:0] mask;
		logic [7:0] status;
		logic [31:0] sig_chg;
		logic [esc_pkg::NAT_W-1:0] nat_last;
		logic nat_seen;
		logic [esc_pkg::CNT_W-1:0] err_cnt;
		logic cas_loss;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic irq;
	} esc_state_type;

	esc_state_type st_reg;
	esc_state_type st_next;

	logic cas_en;
	logic [esc_pkg::CNT_W-1:0] cas_thr;
	logic cas_declare;
	logic cas_clear;
	logic nat_chg;
	logic sig_chg_pulse;
	logic [esc_pkg::SIG_CHANNELS-1:0] sig_chg_vec;
	logic [7:0] ev;
	logic [31:0] sig_ev;
	logic acc_done;
	logic rd_done;
	logic wr_done;
	esc_pkg::esc_sel_type sel;

	// ------------------------------------------------------------------
	// Address decode and read mux
	// ------------------------------------------------------------------

	// Map a byte address to a register
	function automatic esc_pkg::esc_sel_type reg_sel(
		input logic [ADDR_W-1:0] a
	);
		logic [15:0] a16;
		a16 = 16'(a);
		case (a16)
			esc_pkg::FRM_CTRL_ADDR: reg_sel = esc_pkg::ESC_SEL_FRM;
			esc_pkg::SIGCHG0_ADDR: reg_sel = esc_pkg::ESC_SEL_SIG0;
			esc_pkg::SIGCHG1_ADDR: reg_sel = esc_pkg::ESC_SEL_SIG1;
			esc_pkg::SIGCHG2_ADDR: reg_sel = esc_pkg::ESC_SEL_SIG2;
			esc_pkg::SIGCHG3_ADDR: reg_sel = esc_pkg::ESC_SEL_SIG3;
			esc_pkg::STATUS_ADDR: reg_sel = esc_pkg::ESC_SEL_STATUS;
			esc_pkg::MASK_ADDR: reg_sel = esc_pkg::ESC_SEL_MASK;
			esc_pkg::CTRL_ADDR: reg_sel = esc_pkg::ESC_SEL_CTRL;
			default: reg_sel = esc_pkg::ESC_SEL_NONE;
		endcase
	endfunction

	// Read value of a register, upper bits zero
	function automatic logic [31:0] reg_read(
		input esc_pkg::esc_sel_type s,
		input esc_state_type q
	);
		case (s)
			esc_pkg::ESC_SEL_FRM: reg_read = {24'h000000, q.frm_ctrl};
			esc_pkg::ESC_SEL_SIG0: reg_read = {24'h000000, q.sig_chg[7:0]};
			esc_pkg::ESC_SEL_SIG1: reg_read = {24'h000000, q.sig_chg[15:8]};
			esc_pkg::ESC_SEL_SIG2: reg_read = {24'h000000, q.sig_chg[23:16]};
			esc_pkg::ESC_SEL_SIG3: reg_read = {24'h000000, q.sig_chg[31:24]};
			esc_pkg::ESC_SEL_STATUS: reg_read = {24'h000000, q.status};
			esc_pkg::ESC_SEL_MASK: reg_read = {24'h000000, q.mask};
			esc_pkg::ESC_SEL_CTRL: reg_read = {24'h000000, q.ctrl};
			default: reg_read = 32'h00000000;
		endcase
	endfunction

	assign sel = reg_sel(paddr);
	// Transfer completes at the edge where pready is seen high
	assign acc_done = psel && penable && st_reg.ready;
	assign rd_done = acc_done && !pwrite;
	assign wr_done = acc_done && pwrite;

	// ------------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------------

	// CAS flags carry meaning only while CAS is enabled
	// gate CAS events
	assign cas_en = st_reg.ctrl[esc_pkg::CTRL_CAS_EN_BIT];

	// Field value n means n+1 consecutive errored patterns
	// loss threshold select
	assign cas_thr = esc_pkg::CNT_W'(
		st_reg.frm_ctrl[esc_pkg::THR_MSB:esc_pkg::THR_LSB]) + 3'h1;

	// Declare on the errored pattern that reaches the threshold
	// declare loss
	assign cas_declare = cas_en && det_i.cas_pat_strobe
		&& det_i.cas_pat_err && !st_reg.cas_loss
		&& ((st_reg.err_cnt + 3'h1) >= cas_thr);

	// A clean pattern ends a declared loss
	// clear loss
	assign cas_clear = cas_en && det_i.cas_pat_strobe
		&& !det_i.cas_pat_err && st_reg.cas_loss;

	// National bits of non-FAS frames compared with the last ones
	// national bit compare
	assign nat_chg = det_i.nfas_strobe && st_reg.nat_seen
		&& (det_i.nat_bits != st_reg.nat_last);

	// Per-channel ABCD memory
	// channel compare
	esc_sig_tracker #(
		.CHANNELS(esc_pkg::SIG_CHANNELS)
	) u_trk (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.strobe_i(det_i.sig_strobe && cas_en),
		.chan_i(det_i.sig_chan),
		.abcd_i(det_i.sig_abcd),
		.chg_o(sig_chg_pulse),
		.chg_vec_o(sig_chg_vec)
	);

	// Event vector in status layout
	always_comb begin
		ev = 8'h00;
		ev[esc_pkg::CAS_FLAG_BIT] = cas_declare || cas_clear;
		ev[esc_pkg::NAT_FLAG_BIT] = nat_chg;
		ev[esc_pkg::SIG_FLAG_BIT] = sig_chg_pulse;
		sig_ev = 32'h00000000;
		sig_ev[esc_pkg::SIG_CHANNELS-1:0] = sig_chg_vec;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_next = st_reg;

		// Errored pattern counter and loss state, frozen without CAS
		if (cas_en && det_i.cas_pat_strobe) begin
			if (det_i.cas_pat_err) begin
				if (cas_declare) begin
					st_next.cas_loss = 1'b1;
					st_next.err_cnt = '0;
				end else if (!st_reg.cas_loss) begin
					st_next.err_cnt = st_reg.err_cnt + 3'h1;
				end
			end else begin
				st_next.err_cnt = '0;
				st_next.cas_loss = 1'b0;
			end
		end

		// Remember the national bits
		if (det_i.nfas_strobe) begin
			st_next.nat_last = det_i.nat_bits;
			st_next.nat_seen = 1'b1;
		end

		// Register writes
		if (wr_done) begin
			case (sel)
				esc_pkg::ESC_SEL_FRM: st_next.frm_ctrl = pwdata[7:0];
				esc_pkg::ESC_SEL_MASK: st_next.mask = pwdata[7:0];
				esc_pkg::ESC_SEL_CTRL: st_next.ctrl = pwdata[7:0];
				default: st_next.frm_ctrl = st_reg.frm_ctrl;
			endcase
		end

		// Read clears exactly the bits returned; new events win
		// clear on read
		st_next.status = st_reg.status;
		st_next.sig_chg = st_reg.sig_chg;
		if (rd_done) begin
			case (sel)
				esc_pkg::ESC_SEL_STATUS:
					st_next.status = st_reg.status & ~st_reg.rdata[7:0];
				esc_pkg::ESC_SEL_SIG0:
					st_next.sig_chg[7:0] = st_reg.sig_chg[7:0]
						& ~st_reg.rdata[7:0];
				esc_pkg::ESC_SEL_SIG1:
					st_next.sig_chg[15:8] = st_reg.sig_chg[15:8]
						& ~st_reg.rdata[7:0];
				esc_pkg::ESC_SEL_SIG2:
					st_next.sig_chg[23:16] = st_reg.sig_chg[23:16]
						& ~st_reg.rdata[7:0];
				esc_pkg::ESC_SEL_SIG3:
					st_next.sig_chg[31:24] = st_reg.sig_chg[31:24]
						& ~st_reg.rdata[7:0];
				default: st_next.status = st_reg.status;
			endcase
		end
		st_next.status = st_next.status | ev;
		st_next.sig_chg = st_next.sig_chg | sig_ev;

		// APB answer one cycle into the access phase
		st_next.ready = psel && penable && !st_reg.ready;
		st_next.rdata = 32'h00000000;
		st_next.slverr = 1'b0;
		if (psel && penable && !st_reg.ready) begin
			st_next.rdata = pwrite ? 32'h00000000 : reg_read(sel, st_reg);
			st_next.slverr = (sel == esc_pkg::ESC_SEL_NONE);
		end

		// Level interrupt from unmasked flags
		st_next.irq = |(st_next.status & st_next.mask);
	end

	// State register
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.frm_ctrl <= esc_pkg::FRM_CTRL_RESET;
			st_reg.ctrl <= esc_pkg::CTRL_RESET;
			st_reg.mask <= esc_pkg::MASK_RESET;
			st_reg.status <= esc_pkg::STATUS_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops
	assign prdata = st_reg.rdata;
	assign pready = st_reg.ready;
	assign pslverr = st_reg.slverr;
	assign cas_loss_o = st_reg.cas_loss;
	assign irq_o = st_reg.irq;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence apb_setup_s;
		psel && !penable;
	endsequence

	sequence apb_access_s;
		psel && penable && !pready;
	endsequence

	sequence status_read_s;
		rd_done && (sel == esc_pkg::ESC_SEL_STATUS);
	endsequence

	// Loss declared on reaching the threshold
	// check declare
	loss_declare_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		cas_en && det_i.cas_pat_strobe && det_i.cas_pat_err
		&& !cas_loss_o && (st_reg.err_cnt + 3'h1 == cas_thr)
		|=> cas_loss_o)
		else $error("loss not declared at threshold");

	// Loss not declared early
	// check no early loss
	loss_early_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		!cas_loss_o && (st_reg.err_cnt + 3'h1 < cas_thr)
		|=> !cas_loss_o)
		else $error("loss declared before threshold");

	// Declaring loss raises the CAS flag
	// check flag on loss
	cas_loss_flag_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(cas_loss_o) |-> st_reg.status[esc_pkg::CAS_FLAG_BIT])
		else $error("loss did not set flag");

	// Clearing loss raises the CAS flag
	// check flag on regain
	cas_regain_flag_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		$fell(cas_loss_o) |-> st_reg.status[esc_pkg::CAS_FLAG_BIT])
		else $error("regain did not set flag");

	// No signaling flag (bit 5) rises while CAS is off
	// check gating
	cas_gate_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		!cas_en && !st_reg.status[esc_pkg::SIG_FLAG_BIT]
		|=> !st_reg.status[esc_pkg::SIG_FLAG_BIT])
		else $error("signaling flag set with CAS off");

	// National bit change flagged
	// check national flag
	nat_flag_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		det_i.nfas_strobe && st_reg.nat_seen
		&& (det_i.nat_bits != st_reg.nat_last)
		|=> st_reg.status[esc_pkg::NAT_FLAG_BIT])
		else $error("national change not flagged");

	// Channel change sets flag and channel bit together
	// check signaling flag
	sig_flag_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		sig_chg_pulse |=> st_reg.status[esc_pkg::SIG_FLAG_BIT]
		&& ((st_reg.sig_chg[esc_pkg::SIG_CHANNELS-1:0]
		& $past(sig_chg_vec)) == $past(sig_chg_vec)))
		else $error("signaling change not recorded");

	// A channel change marks exactly one channel bit
	// check channel bit
	sig_chan_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		sig_chg_pulse |-> $onehot(sig_chg_vec))
		else $error("change not one channel");

	// Reading status with no event leaves it clear of read bits
	// check read clear
	read_clear_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		status_read_s ##0 (ev == 8'h00)
		|=> (st_reg.status & $past(st_reg.rdata[7:0])) == 8'h00)
		else $error("read did not clear status");

	// Event during clearing read survives
	// check set wins
	set_wins_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		status_read_s ##0 (ev != 8'h00)
		|=> (st_reg.status & $past(ev)) == $past(ev))
		else $error("event lost in clearing read");

	// APB answer two cycles after setup
	apb_answer_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		apb_setup_s ##1 apb_access_s |=> pready)
		else $error("pready late");

	// Interrupt follows unmasked status
	irq_level_a: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		irq_o == |(st_reg.status & st_reg.mask))
		else $error("interrupt level wrong");

endmodule // esc_status

`default_nettype wire

// ---- verif/esc_status_test.sv ----
// Purpose: Self-checking bench for the E1 signaling change status block
// Assumes: APB master driven on rising edges, detector pulses one cycle
// Notes: Every scenario is its own task and judges its own results
`timescale 1ns/1ps
`default_nettype none

module esc_status_test;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	esc_pkg::esc_det_type det_i = '0;
	logic cas_loss_o;
	logic irq_o;
	int err_total = 0;
	int checks_done = 0;

	esc_status dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .det_i(det_i), .cas_loss_o(cas_loss_o),
		.irq_o(irq_o));

	// Clock at 125 MHz
	always #4 mclk_i = ~mclk_i;

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic wrap_up();
		$display("Counts: %0d mismatches, %0d checks", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready !== 1'b1);
		// Answer comes in the second access cycle
		chk("answer cycles", 32'h2, 32'(n));
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		chk("write error", 32'h0, {31'h0, e});
	endtask

	task automatic rd(input string what, input logic [15:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(what, exp, q);
		chk("read error", 32'h0, {31'h0, e});
	endtask

	// One detector report, then settle
	task automatic pulse(input esc_pkg::esc_det_type d);
		@(posedge mclk_i);
		det_i <= d;
		@(posedge mclk_i);
		det_i <= '0;
		#1;
	endtask

	task automatic cas_pat(input logic err);
		esc_pkg::esc_det_type d;
		d = '0;
		d.cas_pat_strobe = 1'b1;
		d.cas_pat_err = err;
		pulse(d);
	endtask

	task automatic nat(input logic [4:0] b);
		esc_pkg::esc_det_type d;
		d = '0;
		d.nfas_strobe = 1'b1;
		d.nat_bits = b;
		pulse(d);
	endtask

	task automatic sig(input logic [4:0] c, input logic [3:0] v);
		esc_pkg::esc_det_type d;
		d = '0;
		d.sig_strobe = 1'b1;
		d.sig_chan = c;
		d.sig_abcd = v;
		pulse(d);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Reset values, read-write access and refused addresses
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		chk("irq at reset", 32'h0, {31'h0, irq_o});
		chk("loss at reset", 32'h0, {31'h0, cas_loss_o});
		rd("status reset", esc_pkg::STATUS_ADDR, 32'h0);
		rd("framing reset", esc_pkg::FRM_CTRL_ADDR, 32'h0);
		rd("mask reset", esc_pkg::MASK_ADDR, 32'h0);
		rd("ctrl reset", esc_pkg::CTRL_ADDR, 32'h0);
		wr(esc_pkg::FRM_CTRL_ADDR, 32'hFFFF_FF60);
		rd("framing back", esc_pkg::FRM_CTRL_ADDR, 32'h60);
		wr(esc_pkg::STATUS_ADDR, 32'h0000_00E0);
		rd("status write", esc_pkg::STATUS_ADDR, 32'h0);
		apb(1'b0, 16'h0FF0, 32'h0, q, e);
		chk("unmapped data", 32'h0, q);
		chk("unmapped error", 32'h1, {31'h0, e});
	endtask

	// Loss after n+1 errored patterns for every threshold code
	task automatic t_cas();
		wr(esc_pkg::CTRL_ADDR, 32'h1);
		for (int n = 0; n < 4; n++) begin
			wr(esc_pkg::FRM_CTRL_ADDR, 32'(n) << esc_pkg::THR_LSB);
			for (int k = 0; k < n; k++) cas_pat(1'b1);
			cas_pat(1'b0);
			chk("count reset", 32'h0, {31'h0, cas_loss_o});
			for (int k = 0; k <= n; k++) begin
				cas_pat(1'b1);
				chk("loss", 32'(k == n), {31'h0, cas_loss_o});
			end
			rd("loss flag", esc_pkg::STATUS_ADDR, 32'h80);
			rd("flag cleared", esc_pkg::STATUS_ADDR, 32'h0);
			cas_pat(1'b0);
			chk("regain", 32'h0, {31'h0, cas_loss_o});
			rd("regain flag", esc_pkg::STATUS_ADDR, 32'h80);
		end
	endtask

	// National bit change with the interrupt unmasked
	task automatic t_nat();
		wr(esc_pkg::MASK_ADDR, 32'h40);
		nat(5'h11);
		nat(5'h11);
		chk("irq no change", 32'h0, {31'h0, irq_o});
		nat(5'h12);
		chk("irq on change", 32'h1, {31'h0, irq_o});
		rd("nat flag", esc_pkg::STATUS_ADDR, 32'h40);
		#1;
		chk("irq after read", 32'h0, {31'h0, irq_o});
	endtask

	// Signaling change and the per-channel culprit registers
	task automatic t_sig();
		sig(5'd9, 4'h3);
		sig(5'd9, 4'h3);
		rd("sig none", esc_pkg::STATUS_ADDR, 32'h0);
		sig(5'd9, 4'hA);
		chk("masked irq", 32'h0, {31'h0, irq_o});
		rd("sig flag", esc_pkg::STATUS_ADDR, 32'h20);
		rd("chan 9", esc_pkg::SIGCHG1_ADDR, 32'h02);
		rd("chan 9 clr", esc_pkg::SIGCHG1_ADDR, 32'h0);
		sig(5'd29, 4'h1);
		sig(5'd29, 4'h8);
		sig(5'd30, 4'hF);
		rd("chan 29", esc_pkg::SIGCHG3_ADDR, 32'h20);
		rd("chan 0", esc_pkg::SIGCHG0_ADDR, 32'h0);
		rd("sig flag 29", esc_pkg::STATUS_ADDR, 32'h20);
	endtask

	// CAS disabled: bits 7 and 5 frozen, bit 6 still live
	task automatic t_cas_off();
		wr(esc_pkg::CTRL_ADDR, 32'h0);
		sig(5'd9, 4'h5);
		for (int k = 0; k < 4; k++) cas_pat(1'b1);
		chk("loss frozen", 32'h0, {31'h0, cas_loss_o});
		nat(5'h00);
		rd("gated", esc_pkg::STATUS_ADDR, 32'h40);
		rd("chan 9 gated", esc_pkg::SIGCHG1_ADDR, 32'h0);
	endtask

	// Event landing in the completion cycle of a clearing read
	task automatic t_race();
		fork
			rd("race first", esc_pkg::STATUS_ADDR, 32'h0);
			begin
				repeat (2) @(posedge mclk_i);
				nat(5'h1F);
			end
		join
		rd("race kept", esc_pkg::STATUS_ADDR, 32'h40);
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_cas();
		t_nat();
		t_sig();
		t_cas_off();
		t_race();
		wrap_up();
	end

	// Cut a hang short well beyond the expected run
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end
endmodule // esc_status_test

`default_nettype wire
